/* File: common/line_pkg.sv */
// constants for the line sense and termination control block
package line_pkg;

    // ------------------------------------------------------------
    // register offsets (5-bit secondary frame address)
    // ------------------------------------------------------------
    localparam logic [4:0] HOOK_CTRL_OFFSET = 5'h05;
    localparam logic [4:0] LINE_TERM_CTRL_OFFSET = 5'h10;
    localparam logic [4:0] LINE_SENSE_STATUS_OFFSET = 5'h13;

    // ------------------------------------------------------------
    // hook control fields
    // ------------------------------------------------------------
    localparam int HOOK_REQUEST_BIT = 0;
    localparam int ONHOOK_MONITOR_BIT = 1;
    localparam int SENSE_MODE_BIT = 2;
    localparam logic [7:0] HOOK_CTRL_RESET = 8'h00;
    localparam logic [7:0] HOOK_CTRL_MASK = 8'h07;

    // ------------------------------------------------------------
    // line termination control fields
    // ------------------------------------------------------------
    localparam int PARALLEL_OP_BIT = 0;
    localparam int CURRENT_LIMIT_BIT = 1;
    localparam int DCT_LSB = 2;
    localparam int DCT_MSB = 3;
    localparam int AC_TERM_BIT = 4;
    localparam int VOLTAGE_ADJUST_BIT = 5;
    localparam logic [7:0] LINE_TERM_CTRL_RESET = 8'h08;
    localparam logic [7:0] LINE_TERM_CTRL_MASK = 8'h3F;

    // ------------------------------------------------------------
    // line sense status fields
    // ------------------------------------------------------------
    localparam int SENSE_LSB = 0;
    localparam int SENSE_MSB = 4;
    localparam int DROPOUT_BIT = 5;

    // ------------------------------------------------------------
    // dc termination encodings
    // ------------------------------------------------------------
    localparam logic [1:0] DCT_LOW_VOLTAGE = 2'h0;
    localparam logic [1:0] DCT_JAPAN = 2'h1;
    localparam logic [1:0] DCT_FCC = 2'h2;
    localparam logic [1:0] DCT_CTR21 = 2'h3;

    // ------------------------------------------------------------
    // line sense coding
    // ------------------------------------------------------------
    localparam logic [4:0] CODE_ZERO = 5'h00;
    localparam logic [4:0] CODE_MAX_NORMAL = 5'h1E;
    localparam logic [4:0] CODE_OVERLOAD = 5'h1F;
    // voltage input in quarter volts
    localparam int VOLT_QUARTERS_PER_STEP = 11;
    localparam int VOLT_ZERO_LIMIT_Q = 12;
    localparam int VOLT_FULL_SCALE_Q = 348;
    // current input in mA
    localparam int CURRENT_MA_PER_STEP = 3;
    localparam int OVERLOAD_MA = 140;
    localparam int OVERLOAD_CTR21_MA = 54;
    localparam int CURRENT_LIMIT_MA = 60;

    // ------------------------------------------------------------
    // timing in sample periods
    // ------------------------------------------------------------
    localparam int OFFHOOK_SETTLE_SAMPLES = 1548;
    localparam int FILTER_GROUP_DELAY_SAMPLES = 12;
    localparam int SETTLE_CNT_W = 16;
    // filter edges as fraction of sample rate, times 10000
    localparam int FILTER_PASS_EDGE_X10000 = 4125;
    localparam int FILTER_3DB_EDGE_X10000 = 4500;

    // ------------------------------------------------------------
    // hook state machine
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        HOOK_ON = 3'b001,
        HOOK_SETTLING = 3'b010,
        HOOK_OFF = 3'b100
    } hook_state_e;

endpackage : line_pkg

/* File: rtl/input_sync3.sv */
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module input_sync3 #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] out_reg;
    logic [WIDTH-1:0] out_next;

    if (WIDTH < 1)
    begin : bad_width
        $error("input_sync3 width must be positive");
    end

    // ------------------------------------------------------------
    // accept a change once stages two and three agree
    // ------------------------------------------------------------
    always_comb
    begin
        out_next = out_reg;
        if (s2_reg == s3_reg)
        begin
            out_next = s3_reg;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            out_reg <= '0;
        end
        else if (clk_en)
        begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            out_reg <= out_next;
        end
    end

    assign dout = out_reg;

endmodule : input_sync3

/* File: rtl/line_sense_termination_ctrl.sv */
// line sense reporting, hook sequencing and termination select logic
`timescale 1ns/1ps
module line_sense_termination_ctrl #(
    parameter int SETTLE_SAMPLES = line_pkg::OFFHOOK_SETTLE_SAMPLES,
    parameter int VOLT_W = 10,
    parameter int CUR_W = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic sample_tick,
    input wire logic frame_valid,
    input wire logic frame_read,
    input wire logic [4:0] frame_addr,
    input wire logic [7:0] frame_wdata,
    output logic [7:0] frame_rdata,
    output logic frame_rdata_valid,
    input wire logic [VOLT_W-1:0] line_voltage_raw,
    input wire logic [CUR_W-1:0] loop_current_raw,
    input wire logic [4:0] monitor_raw,
    input wire logic dropout_raw,
    output logic hook_switch_on,
    output logic line_data_valid,
    output logic [1:0] dc_mode,
    output logic ac_complex,
    output logic dc_high_impedance,
    output logic current_limit_on,
    output logic voltage_adjust_on
);

    localparam int FILT_TOTAL = line_pkg::FILTER_PASS_EDGE_X10000 + line_pkg::FILTER_3DB_EDGE_X10000;
    localparam int SIN_W = VOLT_W + CUR_W + 6;

    if (SETTLE_SAMPLES <= line_pkg::FILTER_GROUP_DELAY_SAMPLES || SETTLE_SAMPLES > 65535)
    begin : bad_settle
        $error("settle count must exceed group delay and fit 16 bits");
    end
    if (VOLT_W < 9 || VOLT_W > 16 || CUR_W < 8 || CUR_W > 16 || FILT_TOTAL <= 0)
    begin : bad_width
        $error("input widths out of range");
    end

    // ------------------------------------------------------------
    // pin input synchronisation
    // ------------------------------------------------------------
    logic [SIN_W-1:0] sense_raw;
    logic [SIN_W-1:0] sense_sync;
    logic [VOLT_W-1:0] volt_s;
    logic [CUR_W-1:0] cur_s;
    logic [4:0] mon_s;
    logic dropout_s;

    assign sense_raw = {dropout_raw, monitor_raw, loop_current_raw, line_voltage_raw};

    input_sync3 #(
        .WIDTH(SIN_W)
    ) u_sense_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .din(sense_raw),
        .dout(sense_sync)
    );

    assign volt_s = sense_sync[VOLT_W-1:0];
    assign cur_s = sense_sync[VOLT_W+CUR_W-1:VOLT_W];
    assign mon_s = sense_sync[VOLT_W+CUR_W+4:VOLT_W+CUR_W];
    assign dropout_s = sense_sync[SIN_W-1];

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    logic [7:0] hook_ctrl_reg;
    logic [7:0] hook_ctrl_next;
    logic [7:0] term_ctrl_reg;
    logic [7:0] term_ctrl_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic [7:0] status_word;
    logic [4:0] line_sense_reg;
    logic dropout_reg;

    assign status_word = {2'h0, dropout_reg, line_sense_reg};

    always_comb
    begin
        hook_ctrl_next = hook_ctrl_reg;
        term_ctrl_next = term_ctrl_reg;
        rdata_next = rdata_reg;
        rvalid_next = 1'b0;
        if (frame_valid && frame_read)
        begin
            rvalid_next = 1'b1;
            rdata_next = 8'h00;
            if (frame_addr == line_pkg::HOOK_CTRL_OFFSET)
            begin
                rdata_next = hook_ctrl_reg;
            end
            else if (frame_addr == line_pkg::LINE_TERM_CTRL_OFFSET)
            begin
                rdata_next = term_ctrl_reg;
            end
            else if (frame_addr == line_pkg::LINE_SENSE_STATUS_OFFSET)
            begin
                rdata_next = status_word;
            end
        end
        else if (frame_valid)
        begin
            if (frame_addr == line_pkg::HOOK_CTRL_OFFSET)
            begin
                hook_ctrl_next = frame_wdata & line_pkg::HOOK_CTRL_MASK;
            end
            else if (frame_addr == line_pkg::LINE_TERM_CTRL_OFFSET)
            begin
                term_ctrl_next = frame_wdata & line_pkg::LINE_TERM_CTRL_MASK;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            hook_ctrl_reg <= line_pkg::HOOK_CTRL_RESET;
            term_ctrl_reg <= line_pkg::LINE_TERM_CTRL_RESET;
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            hook_ctrl_reg <= hook_ctrl_next;
            term_ctrl_reg <= term_ctrl_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    // ------------------------------------------------------------
    // hook sequencing
    // ------------------------------------------------------------
    line_pkg::hook_state_e hook_state_reg;
    line_pkg::hook_state_e hook_state_next;
    logic [line_pkg::SETTLE_CNT_W-1:0] settle_cnt_reg;
    logic [line_pkg::SETTLE_CNT_W-1:0] settle_cnt_next;
    logic hook_req;
    localparam logic [line_pkg::SETTLE_CNT_W-1:0] SETTLE_CNT_LAST = line_pkg::SETTLE_CNT_W'(SETTLE_SAMPLES - 1);

    assign hook_req = hook_ctrl_reg[line_pkg::HOOK_REQUEST_BIT];

    always_comb
    begin
        hook_state_next = hook_state_reg;
        settle_cnt_next = settle_cnt_reg;
        case (hook_state_reg)
            line_pkg::HOOK_ON:
            begin
                settle_cnt_next = '0;
                if (hook_req)
                begin
                    hook_state_next = line_pkg::HOOK_SETTLING;
                end
            end
            line_pkg::HOOK_SETTLING:
            begin
                if (!hook_req)
                begin
                    hook_state_next = line_pkg::HOOK_ON;
                end
                else if (sample_tick)
                begin
                    if (settle_cnt_reg == SETTLE_CNT_LAST)
                    begin
                        hook_state_next = line_pkg::HOOK_OFF;
                    end
                    else
                    begin
                        settle_cnt_next = settle_cnt_reg + 1'b1;
                    end
                end
            end
            line_pkg::HOOK_OFF:
            begin
                if (!hook_req)
                begin
                    hook_state_next = line_pkg::HOOK_ON;
                end
            end
            default:
            begin
                hook_state_next = line_pkg::HOOK_ON;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            hook_state_reg <= line_pkg::HOOK_ON;
            settle_cnt_reg <= '0;
        end
        else if (clk_en)
        begin
            hook_state_reg <= hook_state_next;
            settle_cnt_reg <= settle_cnt_next;
        end
    end

    // ------------------------------------------------------------
    // line sense code
    // ------------------------------------------------------------
    logic [4:0] volt_code;
    logic [4:0] cur_code;
    logic [4:0] sense_next;
    logic ctr21_mode;

    assign ctr21_mode = term_ctrl_reg[line_pkg::DCT_MSB:line_pkg::DCT_LSB] == line_pkg::DCT_CTR21;

    // 2.75 V steps, zero below 3 V
    always_comb
    begin
        int vq;
        vq = int'(volt_s);
        if (vq < line_pkg::VOLT_ZERO_LIMIT_Q)
        begin
            volt_code = line_pkg::CODE_ZERO;
        end
        else if (vq >= line_pkg::VOLT_FULL_SCALE_Q)
        begin
            volt_code = line_pkg::CODE_OVERLOAD;
        end
        else
        begin
            volt_code = 5'((vq - line_pkg::VOLT_ZERO_LIMIT_Q) / line_pkg::VOLT_QUARTERS_PER_STEP + 1);
        end
    end

    always_comb
    begin
        int cma;
        int current_limit_enable;
        cma = int'(cur_s);
        current_limit_enable = ctr21_mode ? line_pkg::OVERLOAD_CTR21_MA : line_pkg::OVERLOAD_MA;
        if (cma > current_limit_enable)
        begin
            cur_code = line_pkg::CODE_OVERLOAD;
        end
        else if (cma / line_pkg::CURRENT_MA_PER_STEP >= int'(line_pkg::CODE_MAX_NORMAL))
        begin
            cur_code = line_pkg::CODE_MAX_NORMAL;
        end
        else
        begin
            cur_code = 5'(cma / line_pkg::CURRENT_MA_PER_STEP);
        end
    end

    // source selected by hook and mode
    always_comb
    begin
        sense_next = line_pkg::CODE_ZERO;
        if (hook_state_reg != line_pkg::HOOK_ON)
        begin
            sense_next = cur_code;
        end
        else if (hook_ctrl_reg[line_pkg::ONHOOK_MONITOR_BIT])
        begin
            sense_next = mon_s;
        end
        else if (hook_ctrl_reg[line_pkg::SENSE_MODE_BIT])
        begin
            sense_next = volt_code;
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    logic hook_sw_reg;
    logic valid_reg;
    logic [1:0] dc_mode_reg;
    logic ac_reg;
    logic hi_z_reg;
    logic lim_reg;
    logic vadj_reg;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            line_sense_reg <= line_pkg::CODE_ZERO;
            dropout_reg <= 1'b0;
            hook_sw_reg <= 1'b0;
            valid_reg <= 1'b0;
            dc_mode_reg <= line_pkg::DCT_FCC;
            ac_reg <= 1'b0;
            hi_z_reg <= 1'b0;
            lim_reg <= 1'b0;
            vadj_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            line_sense_reg <= sense_next;
            dropout_reg <= dropout_s;
            hook_sw_reg <= hook_state_next != line_pkg::HOOK_ON;
            valid_reg <= hook_state_next == line_pkg::HOOK_OFF;
            dc_mode_reg <= term_ctrl_next[line_pkg::DCT_MSB:line_pkg::DCT_LSB];
            ac_reg <= term_ctrl_next[line_pkg::AC_TERM_BIT];
            hi_z_reg <= term_ctrl_next[line_pkg::PARALLEL_OP_BIT];
            lim_reg <= term_ctrl_next[line_pkg::CURRENT_LIMIT_BIT]
                && term_ctrl_next[line_pkg::DCT_MSB:line_pkg::DCT_LSB] == line_pkg::DCT_CTR21;
            vadj_reg <= term_ctrl_next[line_pkg::VOLTAGE_ADJUST_BIT];
        end
    end

    assign frame_rdata = rdata_reg;
    assign frame_rdata_valid = rvalid_reg;
    assign hook_switch_on = hook_sw_reg;
    assign line_data_valid = valid_reg;
    assign dc_mode = dc_mode_reg;
    assign ac_complex = ac_reg;
    assign dc_high_impedance = hi_z_reg;
    assign current_limit_on = lim_reg;
    assign voltage_adjust_on = vadj_reg;

endmodule : line_sense_termination_ctrl

/* File: tb/line_model.sv */
// line side model: pin levels and sample rate tick
`timescale 1ns/1ps
module line_model #(
    parameter int TICK_DIV = 4
) (
    input wire logic sys_clk,
    input wire logic [9:0] volt_set,
    input wire logic [7:0] cur_set,
    input wire logic [4:0] mon_set,
    input wire logic drop_set,
    output logic sample_tick,
    output logic [9:0] line_voltage_raw,
    output logic [7:0] loop_current_raw,
    output logic [4:0] monitor_raw,
    output logic dropout_raw
);
    int div_cnt = 0;
    initial
    begin
        sample_tick = 1'b0;
        line_voltage_raw = 10'h000;
        loop_current_raw = 8'h00;
        monitor_raw = 5'h00;
        dropout_raw = 1'b0;
    end
    // ------------------------------------------------------------
    // tick and pin drive
    // ------------------------------------------------------------
    always @(posedge sys_clk)
    begin
        div_cnt <= (div_cnt == TICK_DIV - 1) ? 0 : div_cnt + 1;
        sample_tick <= (div_cnt == TICK_DIV - 1);
        line_voltage_raw <= volt_set;
        loop_current_raw <= cur_set;
        monitor_raw <= mon_set;
        dropout_raw <= drop_set;
    end
endmodule : line_model

/* File: tb/line_sense_termination_ctrl_asserts.sv */
// port checker for the line sense and termination block
`timescale 1ns/1ps
module line_sense_termination_ctrl_asserts #(
    parameter int SETTLE_SAMPLES = line_pkg::OFFHOOK_SETTLE_SAMPLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic sample_tick,
    input wire logic frame_valid,
    input wire logic frame_read,
    input wire logic [4:0] frame_addr,
    input wire logic [7:0] frame_wdata,
    input wire logic [7:0] frame_rdata,
    input wire logic frame_rdata_valid,
    input wire logic hook_switch_on,
    input wire logic line_data_valid,
    input wire logic [1:0] dc_mode,
    input wire logic ac_complex,
    input wire logic dc_high_impedance,
    input wire logic current_limit_on,
    input wire logic voltage_adjust_on
);
    logic [15:0] tick_cnt;
    logic rd, wr_hook, wr_term, mapped;
    assign rd = clk_en && frame_valid && frame_read;
    assign wr_hook = clk_en && frame_valid && !frame_read && frame_addr == line_pkg::HOOK_CTRL_OFFSET;
    assign wr_term = clk_en && frame_valid && !frame_read && frame_addr == line_pkg::LINE_TERM_CTRL_OFFSET;
    assign mapped = frame_addr inside {line_pkg::HOOK_CTRL_OFFSET, line_pkg::LINE_TERM_CTRL_OFFSET,
        line_pkg::LINE_SENSE_STATUS_OFFSET};

    // ------------------------------------------------------------
    // settle tick counter
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
        if (!rst_n || !hook_switch_on)
            tick_cnt <= 16'h0000;
        else if (clk_en && sample_tick && !line_data_valid)
            tick_cnt <= tick_cnt + 16'h0001;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    AST_READ_ANSWER: assert property (rd |=> frame_rdata_valid)
        else $error("read frame not answered");
    AST_NO_STRAY_VALID: assert property (frame_rdata_valid |-> $past(rd))
        else $error("read valid without read frame");
    AST_RDATA_HOLDS: assert property (!frame_rdata_valid |-> $stable(frame_rdata))
        else $error("read data moved without read");
    AST_UNMAPPED_ZERO: assert property (rd && !mapped |=> frame_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_HOOK_SET: assert property (wr_hook && frame_wdata[0] |-> ##2 hook_switch_on)
        else $error("hook request not followed");
    AST_HOOK_HOLD: assert property ($fell(hook_switch_on) && $past(rst_n)
        |-> $past(wr_hook && !frame_wdata[0], 2))
        else $error("hook dropped without clear");
    AST_HOOK_CLEAR: assert property (wr_hook && !frame_wdata[0] |-> ##2 !hook_switch_on && !line_data_valid)
        else $error("hook clear not followed");
    AST_SETTLE_COUNT: assert property ($rose(line_data_valid) |-> tick_cnt == SETTLE_SAMPLES)
        else $error("line data valid at wrong tick count");
    AST_VALID_NEEDS_HOOK: assert property (line_data_valid |-> hook_switch_on && tick_cnt == SETTLE_SAMPLES)
        else $error("line data valid without settled hook");
    AST_TERM_MODES: assert property (wr_term |=> dc_mode == $past(frame_wdata[3:2]) && ac_complex == $past(frame_wdata[4]))
        else $error("termination select not applied");
    AST_LIMIT_CTR21: assert property (wr_term |=> current_limit_on == ($past(frame_wdata[1]) && $past(frame_wdata[3:2]) == 2'h3))
        else $error("current limit not tied to ctr21");
    AST_PARALLEL_VOL: assert property (wr_term |=> dc_high_impedance == $past(frame_wdata[0])
        && voltage_adjust_on == $past(frame_wdata[5]))
        else $error("parallel or voltage adjust not applied");

    cover property (rd && frame_addr == line_pkg::LINE_SENSE_STATUS_OFFSET);
    cover property ($rose(line_data_valid));
    cover property (wr_hook && !frame_wdata[0] && hook_switch_on && !line_data_valid);
endmodule : line_sense_termination_ctrl_asserts

/* File: tb/tb_line_sense_termination_ctrl.sv */
// self-checking bench for the line sense and termination block
`timescale 1ns/1ps
module tb_line_sense_termination_ctrl;
    localparam int SETTLE = 16;
    localparam int TDIV = 4;
    localparam logic [4:0] A_HOOK = line_pkg::HOOK_CTRL_OFFSET;
    localparam logic [4:0] A_TERM = line_pkg::LINE_TERM_CTRL_OFFSET;
    localparam logic [4:0] A_STAT = line_pkg::LINE_SENSE_STATUS_OFFSET;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic frame_valid = 1'b0;
    logic frame_read = 1'b0;
    logic [4:0] frame_addr = 5'h00;
    logic [7:0] frame_wdata = 8'h00;
    logic [9:0] volt_set = 10'h000;
    logic [7:0] cur_set = 8'h00;
    logic [4:0] mon_set = 5'h00;
    logic drop_set = 1'b0;
    logic sample_tick, dropout_raw, frame_rdata_valid, hook_switch_on, line_data_valid;
    logic ac_complex, dc_high_impedance, current_limit_on, voltage_adjust_on;
    logic [9:0] line_voltage_raw;
    logic [7:0] loop_current_raw, frame_rdata, rd, w;
    logic [4:0] monitor_raw;
    logic [1:0] dc_mode;
    int error_cnt = 0;
    int samples_checked = 0;
    int n, q;
    int vq[8] = '{0, 11, 12, 22, 23, 347, 348, 1023};
    int cm[6] = '{0, 3, 54, 55, 140, 141};
    int lv[3] = '{6, 12, 30};

    initial
    begin
        forever #20 sys_clk = ~sys_clk;
    end

    line_model #(.TICK_DIV(TDIV)) i_line_model (.sys_clk(sys_clk), .volt_set(volt_set), .cur_set(cur_set),
        .mon_set(mon_set), .drop_set(drop_set), .sample_tick(sample_tick), .line_voltage_raw(line_voltage_raw),
        .loop_current_raw(loop_current_raw), .monitor_raw(monitor_raw), .dropout_raw(dropout_raw));
    line_sense_termination_ctrl #(.SETTLE_SAMPLES(SETTLE)) i_line_sense_termination_ctrl (.sys_clk(sys_clk),
        .rst_n(rst_n), .clk_en(clk_en), .sample_tick(sample_tick), .frame_valid(frame_valid),
        .frame_read(frame_read), .frame_addr(frame_addr), .frame_wdata(frame_wdata), .frame_rdata(frame_rdata),
        .frame_rdata_valid(frame_rdata_valid), .line_voltage_raw(line_voltage_raw),
        .loop_current_raw(loop_current_raw), .monitor_raw(monitor_raw), .dropout_raw(dropout_raw),
        .hook_switch_on(hook_switch_on), .line_data_valid(line_data_valid), .dc_mode(dc_mode),
        .ac_complex(ac_complex), .dc_high_impedance(dc_high_impedance), .current_limit_on(current_limit_on),
        .voltage_adjust_on(voltage_adjust_on));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic frame(input logic r, input logic [4:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        frame_valid <= 1'b1;
        frame_read <= r;
        frame_addr <= a;
        frame_wdata <= d;
        @(posedge sys_clk);
        frame_valid <= 1'b0;
        #1;
        rd = frame_rdata;
        if (r)
            check({7'h00, frame_rdata_valid}, 8'h01);
    endtask : frame

    task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
        frame(1'b1, a, 8'h00);
        check(rd, exp);
    endtask : rd_chk

    task automatic set_line(input int v, input int c, input int m, input logic dr);
        @(posedge sys_clk);
        volt_set <= v[9:0];
        cur_set <= c[7:0];
        mon_set <= m[4:0];
        drop_set <= dr;
        repeat (8) @(posedge sys_clk);
    endtask : set_line

    function automatic logic [7:0] vcode(input int v);
        if (v < 12)
            return 8'h00;
        if (v >= 348)
            return 8'h1F;
        return 8'((v - 12) / 11 + 1);
    endfunction : vcode

    function automatic logic [7:0] ccode(input int ma, input logic ctr);
        if (ma > (ctr ? 54 : 140))
            return 8'h1F;
        return (ma / 3 > 30) ? 8'h1E : 8'(ma / 3);
    endfunction : ccode

    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        report_and_stop();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(64));
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd_chk(A_HOOK, 8'h00);
        rd_chk(A_TERM, 8'h08);
        check({6'h00, dc_mode}, 8'h02);
        rd_chk(5'h07, 8'h00);
        set_line(0, 0, 0, 1'b1);
        rd_chk(A_STAT, 8'h20);
        frame(1'b0, A_STAT, 8'hFF);
        rd_chk(A_STAT, 8'h20);
        for (int i = 0; i < 8; i++)
        begin
            w = 8'($urandom());
            w[3:2] = i[1:0];
            w[1] = i[2];
            frame(1'b0, A_TERM, w);
            check({6'h00, dc_mode}, {6'h00, w[3:2]});
            check({7'h00, current_limit_on}, {7'h00, w[1] & (w[3:2] == 2'h3)});
            check({6'h00, ac_complex, dc_high_impedance}, {6'h00, w[4], w[0]});
            rd_chk(A_TERM, w & 8'h3F);
        end
        frame(1'b0, A_HOOK, 8'h04);
        for (int i = 0; i < 20; i++)
        begin
            q = (i < 8) ? vq[i] : $urandom_range(1023, 0);
            set_line(q, 0, 0, 1'b0);
            rd_chk(A_STAT, vcode(q));
        end
        frame(1'b0, A_HOOK, 8'h06);
        repeat (4)
        begin
            q = $urandom_range(31, 0);
            set_line(100, 0, q, 1'b0);
            rd_chk(A_STAT, 8'(q));
        end
        frame(1'b0, A_HOOK, 8'h00);
        rd_chk(A_STAT, 8'h00);
        frame(1'b0, A_HOOK, 8'h01);
        repeat (5 * TDIV) @(negedge sys_clk);
        check({7'h00, hook_switch_on}, 8'h01);
        frame(1'b0, A_HOOK, 8'h00);
        repeat (2) @(negedge sys_clk);
        check({6'h00, hook_switch_on, line_data_valid}, 8'h00);
        frame(1'b0, A_HOOK, 8'h01);
        @(posedge sys_clk);
        n = 0;
        repeat (SETTLE * TDIV * 2)
        begin
            @(negedge sys_clk);
            if (line_data_valid === 1'b1)
                break;
            if (sample_tick === 1'b1)
                n++;
        end
        check(8'(n), 8'(SETTLE));
        check({7'h00, line_data_valid}, 8'h01);
        for (int i = 0; i < 24; i++)
        begin
            q = (i < 12) ? cm[i / 2] : $urandom_range(200, 0);
            frame(1'b0, A_TERM, i[0] ? 8'h0C : 8'h08);
            set_line(0, q, 0, 1'b0);
            rd_chk(A_STAT, ccode(q, i[0]));
        end
        check({7'h00, hook_switch_on}, 8'h01);
        set_line(0, 0, 0, 1'b1);
        rd_chk(A_STAT, 8'h20);
        frame(1'b0, A_TERM, 8'h0E);
        set_line(0, 15, 0, 1'b0);
        frame(1'b1, A_STAT, 8'h00);
        if (rd[4:0] < 5'h06)
            frame(1'b0, A_TERM, 8'h08);
        check({6'h00, dc_mode}, 8'h02);
        for (int i = 0; i < 3; i++)
        begin
            frame(1'b0, A_TERM, 8'h20);
            set_line(0, lv[i], 0, 1'b0);
            frame(1'b1, A_STAT, 8'h00);
            if (rd[4:0] > 5'h02)
                frame(1'b0, A_TERM, (rd[4:0] < 5'h06) ? 8'h24 : 8'h08);
            check({6'h00, dc_mode}, 8'(i));
            check({7'h00, voltage_adjust_on}, {7'h00, i < 2});
        end
        frame(1'b0, A_TERM, 8'h04);
        check({6'h00, dc_mode}, 8'h01);
        frame(1'b0, A_HOOK, 8'h04);
        set_line(100, 50, 0, 1'b0);
        rd_chk(A_STAT, vcode(100));
        check({6'h00, hook_switch_on, line_data_valid}, 8'h00);
        report_and_stop();
    end
endmodule : tb_line_sense_termination_ctrl

bind line_sense_termination_ctrl line_sense_termination_ctrl_asserts #(.SETTLE_SAMPLES(SETTLE_SAMPLES))
    i_line_sense_termination_ctrl_asserts (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
    .sample_tick(sample_tick), .frame_valid(frame_valid), .frame_read(frame_read), .frame_addr(frame_addr),
    .frame_wdata(frame_wdata), .frame_rdata(frame_rdata), .frame_rdata_valid(frame_rdata_valid),
    .hook_switch_on(hook_switch_on), .line_data_valid(line_data_valid), .dc_mode(dc_mode),
    .ac_complex(ac_complex), .dc_high_impedance(dc_high_impedance), .current_limit_on(current_limit_on),
    .voltage_adjust_on(voltage_adjust_on));
